// ===== pfs_pkg.sv
// Constants, offsets and carrier types of the frequency-select control.
// Assumes a 32-bit register port and a single 50 MHz reference clock.
package pfs_pkg;
    localparam int AW = 8;
    localparam int DW = 32;
    localparam int ROWS = 8;
    localparam int NDIV = 6;
    // Register offsets
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_CAP    = 8'h04;
    localparam logic [7:0] OFF_CHOICE = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0C;
    localparam logic [7:0] OFF_ROW0   = 8'h20;
    localparam logic [7:0] OFF_LOOP2  = 8'h40;
    localparam logic [7:0] OFF_LOOP3  = 8'h44;
    localparam logic [7:0] OFF_DIV0   = 8'h60;
    // Control field positions
    localparam int SD_EN_BIT   = 0;
    localparam int SUSP_BIT    = 1;
    localparam int BYPASS_BIT  = 2;
    localparam int XBUF_BIT    = 3;
    localparam int EDIV_LSB    = 4;
    localparam int DRV_LSB     = 6;
    localparam int SMASK_LSB   = 8;
    localparam int LOOPEN_LSB  = 16;
    localparam int SLOOP_LSB   = 19;
    // Values after reset
    localparam logic [31:0] CTRL_RST   = 32'h0007_0009;
    localparam logic [5:0]  CAP_RST    = 6'h00;
    localparam logic [7:0]  CHOICE_RST = 8'h00;
    localparam logic [18:0] ROW_RST    = 19'h0_0000;
    localparam logic [6:0]  DIV_RST    = 7'h00;
    // Strap capture waits for the synchronisers to refill
    localparam logic [1:0]  STRAP_WAIT = 2'h3;
    // Output E post-divider codes
    localparam logic [1:0]  EDIV_OFF = 2'h0;
    localparam logic [1:0]  EDIV_4   = 2'h1;
    localparam logic [1:0]  EDIV_2   = 2'h2;
    localparam logic [1:0]  EDIV_3   = 2'h3;
    // Load capacitance in femtofarads
    localparam logic [14:0] CAP_STEP_FF = 15'h0177;
    localparam logic [14:0] CAP_MIN_FF  = 15'h1770;
    localparam logic [14:0] CAP_MAX_FF  = 15'h7530;

    typedef struct packed {
        logic        en;
        logic [10:0] p;
        logic [7:0]  q;
    } pfs_loop_t;

    typedef struct packed {
        logic [5:0]  cap;
        logic [1:0]  drive;
        logic        bypass;
        logic        oscOn;
        logic [14:0] loadFf;
    } pfs_xtal_t;

    function automatic pfs_loop_t pfs_to_loop(input logic [18:0] w, input logic en);
        pfs_loop_t r;
        r.en = en;
        r.p  = w[18:8];
        r.q  = w[7:0];
        return r;
    endfunction : pfs_to_loop
endpackage : pfs_pkg

// ===== pfs_sync.sv
// Two-flop synchroniser for a group of pin levels.
// Assumes inputs are asynchronous to clk; only stage two is read.
`timescale 1ns/1ps
module pfs_sync #(
    parameter int W = 4
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // Levels
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= din;
            sync_q <= meta_q;
        end
    end

    assign dout = sync_q;
endmodule : pfs_sync

// ===== pfs_out_div.sv
// Seven-bit linear output divider with period-aligned reload.
// Assumes clk stands in for the divider's source clock.
`timescale 1ns/1ps
module pfs_out_div (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Control
    input  wire logic       run,
    input  wire logic [6:0] divisor,
    // Output
    output logic            clkOut,
    output logic            active
);
    logic [6:0] div_q;
    logic [6:0] cnt_q;
    logic       out_q;
    wire  [6:0] last   = div_q - 7'h01;
    // Widened before the add so that 127 does not wrap to a zero high time
    wire  [6:0] half   = 7'((8'(div_q) + 8'h01) >> 1);
    wire  [6:0] cntInc = cnt_q + 7'h01;
    wire        wrap   = (div_q == 7'h00) || (cnt_q >= last);

    // New divisor taken only at a period boundary, so no runt pulse
    always_ff @(posedge clk) begin
        if (rst || !run) begin
            div_q <= 7'h00;
            cnt_q <= 7'h00;
            out_q <= 1'b0;
        end else if (wrap) begin
            div_q <= divisor;
            cnt_q <= 7'h00;
            out_q <= (divisor != 7'h00);
        end else begin
            cnt_q <= cntInc;
            out_q <= (cntInc < half);
        end
    end

    // Divide by one holds high: a single-edge counter cannot pass clk itself
    assign clkOut = out_q;
    assign active = (div_q != 7'h00);
endmodule : pfs_out_div

// ===== pfs_freq_select.sv
// Frequency-select control: table, straps, dividers, power pins, crystal.
// Assumes clk is the reference, pins are asynchronous, rst is power-on.
//
// The plain strobed port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module pfs_freq_select (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // Register port
    input  wire logic [7:0]       regAddr,
    input  wire logic [31:0]      regWdata,
    input  wire logic             regWrite,
    input  wire logic             regRead,
    output logic      [31:0]      regRdata,
    // Pins
    input  wire logic             serialDataPin,
    input  wire logic             serialClockPin,
    input  wire logic             selectLineTwo,
    input  wire logic             shutdownOeN,
    // Clock outputs
    output logic                  outputA,
    output logic                  outputAOe,
    output logic                  outputB,
    output logic                  outputBOe,
    output logic                  outputC,
    output logic                  outputCOe,
    output logic                  outputD,
    output logic                  outputDOe,
    output logic                  outputE,
    output logic                  outputEOe,
    output logic                  bufRefOut,
    output logic                  bufRefOe,
    // Loop settings
    output pfs_pkg::pfs_loop_t    firstLoop,
    output pfs_pkg::pfs_loop_t    secondLoop,
    output pfs_pkg::pfs_loop_t    thirdLoop,
    // Crystal and chip state
    output pfs_pkg::pfs_xtal_t    xtal,
    output logic                  chipShutdown
);
    // Registers
    logic [31:0] ctrl_q;
    logic [5:0]  cap_q;
    logic [7:0]  choice_q;
    logic [18:0] row_q [pfs_pkg::ROWS];
    logic [18:0] loop2_q;
    logic [18:0] loop3_q;
    logic [6:0]  div_q [pfs_pkg::NDIV];
    logic [31:0] rdata_q;

    // Strap capture
    logic [1:0]  strapCnt_q;
    logic        strapDone_q;
    logic        strapBit0_q;
    logic        strapBit1_q;

    // Applied state
    pfs_pkg::pfs_loop_t first_q;
    pfs_pkg::pfs_loop_t second_q;
    pfs_pkg::pfs_loop_t third_q;
    logic        choiceApplied_q;

    // Pin synchronisers
    logic [3:0]  pinSync;
    wire         bit0Sync = pinSync[0];
    wire         bit1Sync = pinSync[1];
    wire         bit2Sync = pinSync[2];
    wire         oeSync   = pinSync[3];

    pfs_sync #(.W(4)) u_sync (
        .clk  (clk),
        .rst  (rst),
        .din  ({shutdownOeN, selectLineTwo, serialClockPin, serialDataPin}),
        .dout (pinSync)
    );

    // Control fields
    wire         sdEnable   = ctrl_q[pfs_pkg::SD_EN_BIT];
    wire         suspMode   = ctrl_q[pfs_pkg::SUSP_BIT];
    wire         capBypass  = ctrl_q[pfs_pkg::BYPASS_BIT];
    wire         xbufEnable = ctrl_q[pfs_pkg::XBUF_BIT];
    wire [1:0]   eDivCode   = ctrl_q[pfs_pkg::EDIV_LSB +: 2];
    wire [1:0]   oscDrive   = ctrl_q[pfs_pkg::DRV_LSB +: 2];
    wire [5:0]   suspMask   = ctrl_q[pfs_pkg::SMASK_LSB +: 6];
    wire [2:0]   loopEnable = ctrl_q[pfs_pkg::LOOPEN_LSB +: 3];
    wire [2:0]   suspLoops  = ctrl_q[pfs_pkg::SLOOP_LSB +: 3];

    // Power pins
    wire         tristateAll = !oeSync;
    wire         shutdown    = !oeSync && sdEnable;
    wire         suspendOn   = suspMode && !bit2Sync;
    wire         bit2Index   = suspMode ? 1'b0 : bit2Sync;

    // Frequency table index
    wire [2:0]   rowIdx      = {bit2Index, strapBit1_q, strapBit0_q};
    wire         rowChoice   = choice_q[rowIdx];
    wire [2:0]   loopsOn     = loopEnable & ~(suspendOn ? suspLoops : 3'h0)
                               & {3{!shutdown}};

    // Register decode
    wire         rowHit  = (regAddr[7:5] == pfs_pkg::OFF_ROW0[7:5]) && (regAddr[1:0] == 2'h0);
    wire [2:0]   rowSel  = regAddr[4:2];
    wire         divHit  = (regAddr[7:5] == pfs_pkg::OFF_DIV0[7:5]) && (regAddr[1:0] == 2'h0)
                           && (regAddr[4:2] < 3'h6);
    wire [2:0]   divIdx  = regAddr[4:2];
    wire         wrCtrl  = regWrite && (regAddr == pfs_pkg::OFF_CTRL);
    wire         wrCap   = regWrite && (regAddr == pfs_pkg::OFF_CAP);
    wire         wrChoice = regWrite && (regAddr == pfs_pkg::OFF_CHOICE);
    wire         wrLoop2 = regWrite && (regAddr == pfs_pkg::OFF_LOOP2);
    wire         wrLoop3 = regWrite && (regAddr == pfs_pkg::OFF_LOOP3);
    wire         wrRow   = regWrite && rowHit;
    wire         wrDiv   = regWrite && divHit;

    // Control registers
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_q   <= pfs_pkg::CTRL_RST;
            cap_q    <= pfs_pkg::CAP_RST;
            choice_q <= pfs_pkg::CHOICE_RST;
            loop2_q  <= pfs_pkg::ROW_RST;
            loop3_q  <= pfs_pkg::ROW_RST;
        end else begin
            if (wrCtrl) begin
                ctrl_q <= {10'h000, regWdata[21:0]};
            end
            if (wrCap) begin
                cap_q <= regWdata[5:0];
            end
            if (wrChoice) begin
                choice_q <= regWdata[7:0];
            end
            if (wrLoop2) begin
                loop2_q <= regWdata[18:0];
            end
            if (wrLoop3) begin
                loop3_q <= regWdata[18:0];
            end
        end
    end

    // Table rows and divider registers held in arrays
    generate
        for (genvar r = 0; r < pfs_pkg::ROWS; r++) begin : g_row
            always_ff @(posedge clk) begin
                if (rst) begin
                    row_q[r] <= pfs_pkg::ROW_RST;
                end else if (wrRow && (rowSel == 3'(r))) begin
                    row_q[r] <= regWdata[18:0];
                end
            end
        end
        for (genvar d = 0; d < pfs_pkg::NDIV; d++) begin : g_divreg
            always_ff @(posedge clk) begin
                if (rst) begin
                    div_q[d] <= pfs_pkg::DIV_RST;
                end else if (wrDiv && (divIdx == 3'(d))) begin
                    div_q[d] <= regWdata[6:0];
                end
            end
        end
    endgenerate

    // Straps: caught once the synchronisers hold post-reset pin levels
    always_ff @(posedge clk) begin
        if (rst) begin
            strapCnt_q  <= 2'h0;
            strapDone_q <= 1'b0;
            strapBit0_q <= 1'b0;
            strapBit1_q <= 1'b0;
        end else if (!strapDone_q) begin
            if (strapCnt_q == pfs_pkg::STRAP_WAIT) begin
                strapDone_q <= 1'b1;
                strapBit0_q <= bit0Sync;
                strapBit1_q <= bit1Sync;
            end else begin
                strapCnt_q <= strapCnt_q + 2'h1;
            end
        end
    end

    // Applied loop settings; the first loop follows the table row
    always_ff @(posedge clk) begin
        if (rst) begin
            first_q         <= '0;
            second_q        <= '0;
            third_q         <= '0;
            choiceApplied_q <= 1'b0;
        end else begin
            first_q         <= pfs_pkg::pfs_to_loop(row_q[rowIdx], loopsOn[0]);
            second_q        <= pfs_pkg::pfs_to_loop(loop2_q, loopsOn[1]);
            third_q         <= pfs_pkg::pfs_to_loop(loop3_q, loopsOn[2]);
            choiceApplied_q <= rowChoice;
        end
    end

    assign firstLoop  = first_q;
    assign secondLoop = second_q;
    assign thirdLoop  = third_q;

    // Divisors: A and B each pick one of two registers by the one row choice bit
    wire [6:0]   divA = choiceApplied_q ? div_q[1] : div_q[0];
    wire [6:0]   divB = choiceApplied_q ? div_q[3] : div_q[2];
    wire [6:0]   divE = (eDivCode == pfs_pkg::EDIV_4) ? 7'h04 :
                        (eDivCode == pfs_pkg::EDIV_2) ? 7'h02 :
                        (eDivCode == pfs_pkg::EDIV_3) ? 7'h03 : 7'h00;
    wire [6:0]   divisor [5];
    assign divisor[0] = divA;
    assign divisor[1] = divB;
    assign divisor[2] = div_q[4];
    assign divisor[3] = div_q[5];
    assign divisor[4] = divE;

    // E rides on the first loop, so it stops with that loop
    wire [4:0]   divRun = {loopsOn[0], {4{!shutdown}}};
    logic [4:0]  divClk;
    logic [4:0]  divActive;
    wire  [4:0]  outEnable;

    generate
        for (genvar k = 0; k < 5; k++) begin : g_div
            pfs_out_div u_div (
                .clk     (clk),
                .rst     (rst),
                .run     (divRun[k]),
                .divisor (divisor[k]),
                .clkOut  (divClk[k]),
                .active  (divActive[k])
            );
            assign outEnable[k] = divActive[k] && !tristateAll
                                  && !(suspendOn && suspMask[k]);
        end
    endgenerate

    assign outputA   = divClk[0];
    assign outputAOe = outEnable[0];
    assign outputB   = divClk[1];
    assign outputBOe = outEnable[1];
    assign outputC   = divClk[2];
    assign outputCOe = outEnable[2];
    assign outputD   = divClk[3];
    assign outputDOe = outEnable[3];
    assign outputE   = divClk[4];
    assign outputEOe = outEnable[4];

    // Buffered reference is the clock itself; only its enable is logic
    assign bufRefOut = clk;
    assign bufRefOe  = xbufEnable && !tristateAll && !shutdown
                       && !(suspendOn && suspMask[5]);

    // Crystal settings
    wire [14:0]  capSteps = 15'(cap_q) * pfs_pkg::CAP_STEP_FF;
    wire [14:0]  capSum   = pfs_pkg::CAP_MIN_FF + capSteps;
    assign xtal.cap    = cap_q;
    assign xtal.drive  = oscDrive;
    assign xtal.bypass = capBypass;
    assign xtal.oscOn  = !shutdown;
    // Bypassed capacitors present no programmed load
    assign xtal.loadFf = capBypass ? 15'h0000 :
                         (capSum > pfs_pkg::CAP_MAX_FF) ? pfs_pkg::CAP_MAX_FF : capSum;

    assign chipShutdown = shutdown;

    // Read path
    wire [31:0]  statusWord = {20'h00000, 1'b0, shutdown, suspendOn, tristateAll,
                               choiceApplied_q, rowIdx, strapBit1_q, strapBit0_q,
                               1'b0, strapDone_q};
    logic [31:0] readMux;

    always_comb begin
        readMux = 32'h0000_0000;
        if (rowHit) begin
            readMux = {13'h0000, row_q[rowSel]};
        end else if (divHit) begin
            readMux = {25'h0000000, div_q[divIdx]};
        end else begin
            case (regAddr)
                pfs_pkg::OFF_CTRL:   readMux = ctrl_q;
                pfs_pkg::OFF_CAP:    readMux = {26'h0000000, cap_q};
                pfs_pkg::OFF_CHOICE: readMux = {24'h000000, choice_q};
                pfs_pkg::OFF_STATUS: readMux = statusWord;
                pfs_pkg::OFF_LOOP2:  readMux = {13'h0000, loop2_q};
                pfs_pkg::OFF_LOOP3:  readMux = {13'h0000, loop3_q};
                default:             readMux = 32'h0000_0000;
            endcase
        end
    end

    // Read data stand for exactly the cycle after the strobe
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_q <= 32'h0000_0000;
        end else if (regRead) begin
            rdata_q <= readMux;
        end else begin
            rdata_q <= 32'h0000_0000;
        end
    end

    assign regRdata = rdata_q;
endmodule : pfs_freq_select

// ===== pfs_board_model.sv
// Board logic that drives the select, strap and enable pins.
// Assumes the bench sets the wanted levels; pins move just after a clk edge.
`timescale 1ns/1ps
module pfs_board_model (
    // Clock
    input  wire logic clk,
    // Wanted levels
    input  wire logic serialBusy,
    input  wire logic bit0Want,
    input  wire logic bit1Want,
    input  wire logic bit2Want,
    input  wire logic oeWant,
    // Pins
    output logic      serialDataPin,
    output logic      serialClockPin,
    output logic      selectLineTwo,
    output logic      shutdownOeN
);
    initial begin
        serialDataPin  = 1'b1;
        serialClockPin = 1'b0;
        selectLineTwo  = 1'b0;
        shutdownOeN    = 1'b1;
    end
    // While serialBusy is set the serial pins toggle every cycle; otherwise they hold the wanted levels
    always @(posedge clk) begin
        serialDataPin  <= serialBusy ? ~serialDataPin : bit0Want;
        serialClockPin <= serialBusy ? ~serialClockPin : bit1Want;
        selectLineTwo  <= bit2Want;
        shutdownOeN    <= oeWant;
    end
endmodule : pfs_board_model

// ===== pfs_freq_select_asserts.sv
// Concurrent checks on the ports of the frequency-select control.
// Assumes one clk domain with synchronous active-high rst.
`timescale 1ns/1ps
module pfs_freq_select_asserts (
    // Clock and reset
    input wire logic               clk,
    input wire logic               rst,
    // Register strobe and pins
    input wire logic               regWrite,
    input wire logic               selectLineTwo,
    input wire logic               shutdownOeN,
    // Outputs
    input wire logic               outputAOe,
    input wire logic               outputBOe,
    input wire logic               outputCOe,
    input wire logic               outputDOe,
    input wire logic               outputEOe,
    input wire logic               bufRefOut,
    input wire logic               bufRefOe,
    input wire pfs_pkg::pfs_loop_t firstLoop,
    input wire pfs_pkg::pfs_loop_t secondLoop,
    input wire pfs_pkg::pfs_loop_t thirdLoop,
    input wire pfs_pkg::pfs_xtal_t xtal,
    input wire logic               chipShutdown
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    wire logic anyOe = outputAOe | outputBOe | outputCOe | outputDOe | outputEOe | bufRefOe;
    // Cycles since a write or pin move; saturating so a late row change is caught
    logic [2:0] quiet_q;
    logic       sel2_q;
    logic       oe_q;
    always_ff @(posedge clk) begin
        sel2_q <= selectLineTwo;
        oe_q <= shutdownOeN;
        if (rst || regWrite || selectLineTwo != sel2_q || shutdownOeN != oe_q) begin
            quiet_q <= 3'h0;
        end else if (quiet_q != 3'h7) begin
            quiet_q <= quiet_q + 3'h1;
        end
    end
    a_oe_pin_low: assert property (
        !shutdownOeN [*3] |-> !anyOe)
        else $error("Output driven with enable pin low");
    a_shutdown_tristate: assert property (
        chipShutdown |-> !anyOe && !xtal.oscOn
            && (!$past(chipShutdown) || !(firstLoop.en || secondLoop.en || thirdLoop.en)))
        else $error("Output driven during shutdown");
    a_bufref_copy: assert property (
        @(negedge clk) bufRefOut)
        else $error("Buffered reference low while clk high");
    a_load_linear: assert property (
        !xtal.bypass |-> xtal.loadFf == 15'h1770 + 15'h0177 * xtal.cap)
        else $error("Load capacitance not linear in code");
    a_bypass_no_load: assert property (
        xtal.bypass |-> xtal.loadFf == 15'h0000)
        else $error("Load present while bypassed");
    a_xtal_by_write: assert property (
        $changed({xtal.cap, xtal.drive, xtal.bypass}) |-> $past(regWrite))
        else $error("Crystal setting moved without a write");
    a_loops_by_write: assert property (
        $changed({secondLoop.p, secondLoop.q, thirdLoop.p, thirdLoop.q}) |-> $past(regWrite, 2))
        else $error("Second or third loop moved without a write");
    a_row_has_cause: assert property (
        $changed(firstLoop) |-> quiet_q != 3'h7)
        else $error("First loop moved without a cause");
endmodule : pfs_freq_select_asserts

bind pfs_freq_select pfs_freq_select_asserts u_asserts (
    .clk(clk), .rst(rst), .regWrite(regWrite), .selectLineTwo(selectLineTwo),
    .shutdownOeN(shutdownOeN), .outputAOe(outputAOe), .outputBOe(outputBOe),
    .outputCOe(outputCOe), .outputDOe(outputDOe), .outputEOe(outputEOe),
    .bufRefOut(bufRefOut), .bufRefOe(bufRefOe), .firstLoop(firstLoop),
    .secondLoop(secondLoop), .thirdLoop(thirdLoop), .xtal(xtal),
    .chipShutdown(chipShutdown)
);

// ===== pfs_freq_select_tb.sv
// Self-checking bench for the frequency-select control.
// Assumes the board model owns the pins and the bench owns the register port.
`timescale 1ns/1ps
module testbench;
    logic               clk, rst, regWrite, regRead;
    logic [7:0]         regAddr;
    logic [31:0]        regWdata, regRdata;
    logic               serialDataPin, serialClockPin, selectLineTwo, shutdownOeN;
    logic               serialBusy, bit0Want, bit1Want, bit2Want, oeWant;
    logic               outputA, outputB, outputC, outputD, outputE, bufRefOut;
    logic               outputAOe, outputBOe, outputCOe, outputDOe, outputEOe, bufRefOe;
    logic               chipShutdown;
    pfs_pkg::pfs_loop_t firstLoop, secondLoop, thirdLoop;
    pfs_pkg::pfs_xtal_t xtal;
    int                 n_checks, n_mismatch;
    wire logic [4:0]    outs = {outputE, outputD, outputC, outputB, outputA};
    wire logic [5:0]    oeVec = {outputAOe, outputBOe, outputCOe, outputDOe, outputEOe, bufRefOe};
    pfs_freq_select dut (
        .clk(clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
        .regRead(regRead), .regRdata(regRdata), .serialDataPin(serialDataPin),
        .serialClockPin(serialClockPin), .selectLineTwo(selectLineTwo),
        .shutdownOeN(shutdownOeN), .outputA(outputA), .outputAOe(outputAOe),
        .outputB(outputB), .outputBOe(outputBOe), .outputC(outputC), .outputCOe(outputCOe),
        .outputD(outputD), .outputDOe(outputDOe), .outputE(outputE), .outputEOe(outputEOe),
        .bufRefOut(bufRefOut), .bufRefOe(bufRefOe), .firstLoop(firstLoop),
        .secondLoop(secondLoop), .thirdLoop(thirdLoop), .xtal(xtal),
        .chipShutdown(chipShutdown)
    );
    pfs_board_model board (
        .clk(clk), .serialBusy(serialBusy), .bit0Want(bit0Want), .bit1Want(bit1Want),
        .bit2Want(bit2Want), .oeWant(oeWant), .serialDataPin(serialDataPin),
        .serialClockPin(serialClockPin), .selectLineTwo(selectLineTwo),
        .shutdownOeN(shutdownOeN)
    );
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        regAddr  <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        @(negedge clk);
        d = regRdata;
    endtask : rd
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Cycles from one rising edge of an output to the next, seen at falling clk
    task automatic period(input int k, output int n);
        @(negedge clk);
        for (n = 0; n < 400 && outs[k] !== 1'b0; n++) @(negedge clk);
        for (n = 0; n < 400 && outs[k] !== 1'b1; n++) @(negedge clk);
        n = 0;
        while (outs[k] === 1'b1 && n < 400) begin
            @(negedge clk);
            n++;
        end
        while (outs[k] === 1'b0 && n < 400) begin
            @(negedge clk);
            n++;
        end
    endtask : period
    function automatic logic [31:0] rowVal(input int r);
        return 32'(r) * 32'h0000_0101 + 32'h0000_1002;
    endfunction : rowVal
    task automatic test_reset();
        logic [31:0] d;
        rd(pfs_pkg::OFF_CTRL, d);
        chk(d, 32'h0007_0009);
        rd(pfs_pkg::OFF_CAP, d);
        chk(d, 32'h0);
        rd(8'hFC, d);
        chk(d, 32'h0);
        rd(pfs_pkg::OFF_STATUS, d);
        chk(d & 32'hD, 32'h5);
        serialBusy <= 1'b1;
        cyc(10);
        rd(pfs_pkg::OFF_STATUS, d);
        chk(d & 32'hD, 32'h5);
        $display("test_reset done");
    endtask : test_reset
    task automatic test_table();
        for (int r = 0; r < 8; r++) wr(pfs_pkg::OFF_ROW0 + 8'(4 * r), rowVal(r));
        bit2Want <= 1'b1;
        cyc(8);
        chk(32'(firstLoop), 32'h0008_0000 | rowVal(5));
        bit2Want <= 1'b0;
        cyc(8);
        chk(32'(firstLoop), 32'h0008_0000 | rowVal(1));
        wr(pfs_pkg::OFF_CTRL, 32'h0007_000B);
        bit2Want <= 1'b1;
        cyc(8);
        chk(32'(firstLoop), 32'h0008_0000 | rowVal(1));
        wr(pfs_pkg::OFF_CTRL, 32'h0007_0009);
        cyc(8);
        chk(32'(firstLoop), 32'h0008_0000 | rowVal(5));
        wr(pfs_pkg::OFF_LOOP2, 32'h0000_7F81);
        wr(pfs_pkg::OFF_LOOP3, 32'hFFFF_FFFF);
        cyc(3);
        chk(32'(secondLoop), 32'h0008_7F81);
        chk(32'(thirdLoop), 32'h000F_FFFF);
        $display("test_table done");
    endtask : test_table
    task automatic test_divider();
        int n;
        wr(pfs_pkg::OFF_DIV0, 32'h4);
        wr(8'h64, 32'h6);
        wr(8'h68, 32'h3);
        wr(8'h6C, 32'h5);
        wr(8'h70, 32'h7F);
        wr(8'h74, 32'h2);
        wr(pfs_pkg::OFF_CHOICE, 32'h20);
        cyc(16);
        period(0, n);
        chk(n, 6);
        period(1, n);
        chk(n, 5);
        period(2, n);
        chk(n, 127);
        period(3, n);
        chk(n, 2);
        bit2Want <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            period(0, n);
            chk(32'(n == 4 || n == 6), 32'h1);
        end
        period(0, n);
        chk(n, 4);
        period(1, n);
        chk(n, 3);
        wr(pfs_pkg::OFF_DIV0, 32'h0);
        cyc(16);
        chk({outputAOe, outputBOe}, 32'h1);
        $display("test_divider done");
    endtask : test_divider
    task automatic test_edge();
        int n;
        for (int c = 1; c < 4; c++) begin
            wr(pfs_pkg::OFF_CTRL, 32'h0007_0009 | (32'(c) << 4));
            period(4, n);
            period(4, n);
            chk(n, (c == 1) ? 4 : c);
        end
        wr(pfs_pkg::OFF_CTRL, 32'h0007_0009);
        cyc(8);
        chk(outputEOe, 32'h0);
        $display("test_edge done");
    endtask : test_edge
    task automatic test_power();
        oeWant <= 1'b0;
        cyc(6);
        chk(oeVec, 32'h0);
        chk(chipShutdown, 32'h1);
        chk(xtal.oscOn, 32'h0);
        wr(pfs_pkg::OFF_CTRL, 32'h0007_0008);
        cyc(3);
        chk({chipShutdown, oeVec}, 32'h0);
        oeWant <= 1'b1;
        cyc(6);
        chk({outputBOe, bufRefOe}, 32'h3);
        wr(pfs_pkg::OFF_CTRL, 32'h0007_0009);
        $display("test_power done");
    endtask : test_power
    task automatic test_xtal();
        wr(pfs_pkg::OFF_CAP, 32'h3F);
        cyc(3);
        chk({xtal.cap, xtal.loadFf}, {6'h3F, 15'h73B9});
        wr(pfs_pkg::OFF_CTRL, 32'h0007_008D);
        cyc(3);
        chk({xtal.drive, xtal.bypass, xtal.loadFf}, {2'h2, 1'b1, 15'h0});
        $display("test_xtal done");
    endtask : test_xtal
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_sim
    initial begin
        {rst, regWrite, regRead, regAddr, regWdata} = {1'b1, 42'h0};
        {serialBusy, bit0Want, bit1Want, bit2Want, oeWant} = 5'b01001;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        test_reset();
        test_table();
        test_divider();
        test_edge();
        test_power();
        test_xtal();
        end_sim();
    end
    // The tests need well under a thousand cycles; this leaves ample margin
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        end_sim();
    end
endmodule : testbench
